// ==== verilog/clkc_ctrl.v ====
// clock and oscillator control block with apb register access
//
// Function
// - divider codes 0-6 divide fast clock, 7 selects slow
// - source bits pick internal or external oscillator
// - halt keeps fast or slow clock by idle bits
// - clock switch completes within bounded switch delay
// - internal fast frequency field: 8/12/16 MHz, resets zero
// - new internal frequency applied once stable flag high
// - internal enable or frequency change restarts stable flag
// - internal fast enable bit resets to one
// - drive mode frozen while crystal pins and oscillator on
// - external fast enable restarts its stable flag
// - external fast enable bit resets to zero
// - speed-up bit selects fast-start slow crystal mode
// - speed-up bit locked while slow crystal is system clock
// - slow crystal enable restarts its stable flag
// - slow crystal enable bit resets to zero
// - unimplemented bits read zero, writes ignored
`timescale 1ns/100ps
`include "clkc_defs.vh"
module clkc_ctrl #(
	parameter ADDR_W = 4,
	parameter STAB_CNT_W = 20,
	parameter INT_FAST_STAB_CYC = 2048,
	parameter EXT_FAST_STAB_CYC = 4096,
	parameter EXT_SLOW_FAST_CYC = 65536,
	parameter EXT_SLOW_SLOW_CYC = 262144
)(
	input wire clk_sys,
	input wire sys_rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire cpu_halt,
	input wire xtal_pins_en,
	output reg int_fast_osc_run,
	output reg [1:0] int_fast_freq_out,
	output reg ext_fast_osc_run,
	output reg ext_fast_drive_out,
	output reg ext_slow_osc_run,
	output reg ext_slow_speedup_out,
	output reg [2:0] sys_clk_div_out,
	output reg hs_source_out,
	output reg ls_source_out,
	output reg sys_on_slow,
	output reg hs_clk_on,
	output reg ls_clk_on,
	output reg sleep_mode,
	output reg clk_switching
);

	// ****************************************************************
	// register storage
	// ****************************************************************
	reg [2:0] sys_clk_div_sel;
	reg hs_source_sel;
	reg ls_source_sel;
	reg hs_idle_keep;
	reg ls_idle_keep;
	reg [1:0] int_fast_freq_sel;
	reg int_fast_osc_en;
	reg ext_fast_drive_mode;
	reg ext_fast_osc_en;
	reg ext_slow_speedup;
	reg ext_slow_osc_en;

	wire int_fast_stable;
	wire ext_fast_stable;
	wire ext_slow_stable;

	// ****************************************************************
	// apb decode
	// ****************************************************************
	wire acc_phase;
	wire wr_take;
	wire hit_scc;
	wire hit_ifc;
	wire hit_efc;
	wire hit_esc;
	wire mapped;
	reg [7:0] rd_byte;

	// answer one cycle into the access phase; write lands on the pready edge
	assign acc_phase = psel & penable & ~pready;
	assign wr_take = psel & penable & pready & pwrite;
	assign hit_scc = (paddr == `CLKC_OFF_SYS_CLK_CTRL);
	assign hit_ifc = (paddr == `CLKC_OFF_INT_FAST_CTRL);
	assign hit_efc = (paddr == `CLKC_OFF_EXT_FAST_CTRL);
	assign hit_esc = (paddr == `CLKC_OFF_EXT_SLOW_CTRL);
	assign mapped = hit_scc | hit_ifc | hit_efc | hit_esc;

	// read mux; unimplemented positions are zero
	always @*
	begin
		rd_byte = 8'h00;
		if (hit_scc)
		begin
			rd_byte[`CLKC_DIV_HI:`CLKC_DIV_LO] = sys_clk_div_sel;
			rd_byte[`CLKC_HS_SRC] = hs_source_sel;
			rd_byte[`CLKC_LS_SRC] = ls_source_sel;
			rd_byte[`CLKC_HS_KEEP] = hs_idle_keep;
			rd_byte[`CLKC_LS_KEEP] = ls_idle_keep;
		end
		else if (hit_ifc)
		begin
			rd_byte[`CLKC_FREQ_HI:`CLKC_FREQ_LO] = int_fast_freq_sel;
			rd_byte[`CLKC_STABLE_BIT] = int_fast_stable;
			rd_byte[`CLKC_EN_BIT] = int_fast_osc_en;
		end
		else if (hit_efc)
		begin
			rd_byte[`CLKC_MODE_BIT] = ext_fast_drive_mode;
			rd_byte[`CLKC_STABLE_BIT] = ext_fast_stable;
			rd_byte[`CLKC_EN_BIT] = ext_fast_osc_en;
		end
		else if (hit_esc)
		begin
			rd_byte[`CLKC_MODE_BIT] = ext_slow_speedup;
			rd_byte[`CLKC_STABLE_BIT] = ext_slow_stable;
			rd_byte[`CLKC_EN_BIT] = ext_slow_osc_en;
		end
	end

	// bus answer: registered ready, data and error for an unmapped address
	always @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= acc_phase;
			// error stands only beside its ready pulse
			pslverr <= acc_phase & ~mapped;
			if (acc_phase)
				prdata <= {24'h00_0000, rd_byte};
		end
	end

	// ****************************************************************
	// write side effects and guarded fields
	// ****************************************************************
	wire [7:0] wb;
	wire ifc_restart;
	wire efc_restart;
	wire esc_restart;
	wire drive_locked;
	wire speedup_locked;

	assign wb = pwdata[7:0];
	// a write that sets enable from zero or alters the frequency restarts settling
	assign ifc_restart = wr_take & hit_ifc &
		((wb[`CLKC_EN_BIT] & ~int_fast_osc_en) |
		(wb[`CLKC_FREQ_HI:`CLKC_FREQ_LO] != int_fast_freq_sel));
	assign efc_restart = wr_take & hit_efc & wb[`CLKC_EN_BIT] & ~ext_fast_osc_en;
	assign esc_restart = wr_take & hit_esc & wb[`CLKC_EN_BIT] & ~ext_slow_osc_en;
	// drive current may not move under a running crystal
	assign drive_locked = xtal_pins_en & ext_fast_osc_en;
	// slow crystal as system clock pins the speed-up choice
	assign speedup_locked = (sys_clk_div_sel == `CLKC_DIV_SLOW) & ls_source_sel;

	// reset images as 8-bit words so each field is cut out at its own width
	localparam [7:0] RST_SCC = `CLKC_RST_SYS_CLK_CTRL;
	localparam [7:0] RST_IFC = `CLKC_RST_INT_FAST_CTRL;
	localparam [7:0] RST_EFC = `CLKC_RST_EXT_FAST_CTRL;
	localparam [7:0] RST_ESC = `CLKC_RST_EXT_SLOW_CTRL;

	// register writes; bits outside the fields are dropped
	always @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			sys_clk_div_sel <= RST_SCC[`CLKC_DIV_HI:`CLKC_DIV_LO];
			hs_source_sel <= RST_SCC[`CLKC_HS_SRC];
			ls_source_sel <= RST_SCC[`CLKC_LS_SRC];
			hs_idle_keep <= RST_SCC[`CLKC_HS_KEEP];
			ls_idle_keep <= RST_SCC[`CLKC_LS_KEEP];
			int_fast_freq_sel <= RST_IFC[`CLKC_FREQ_HI:`CLKC_FREQ_LO];
			int_fast_osc_en <= RST_IFC[`CLKC_EN_BIT];
			ext_fast_drive_mode <= RST_EFC[`CLKC_MODE_BIT];
			ext_fast_osc_en <= RST_EFC[`CLKC_EN_BIT];
			ext_slow_speedup <= RST_ESC[`CLKC_MODE_BIT];
			ext_slow_osc_en <= RST_ESC[`CLKC_EN_BIT];
		end
		else if (wr_take)
		begin
			if (hit_scc)
			begin
				sys_clk_div_sel <= wb[`CLKC_DIV_HI:`CLKC_DIV_LO];
				hs_source_sel <= wb[`CLKC_HS_SRC];
				ls_source_sel <= wb[`CLKC_LS_SRC];
				hs_idle_keep <= wb[`CLKC_HS_KEEP];
				ls_idle_keep <= wb[`CLKC_LS_KEEP];
			end
			if (hit_ifc)
			begin
				int_fast_freq_sel <= wb[`CLKC_FREQ_HI:`CLKC_FREQ_LO];
				int_fast_osc_en <= wb[`CLKC_EN_BIT];
			end
			if (hit_efc)
			begin
				if (!drive_locked)
					ext_fast_drive_mode <= wb[`CLKC_MODE_BIT];
				ext_fast_osc_en <= wb[`CLKC_EN_BIT];
			end
			if (hit_esc)
			begin
				if (!speedup_locked)
					ext_slow_speedup <= wb[`CLKC_MODE_BIT];
				ext_slow_osc_en <= wb[`CLKC_EN_BIT];
			end
		end
	end

	// ****************************************************************
	// halt handling and oscillator run requests
	// ****************************************************************
	wire hs_keep_now;
	wire ls_keep_now;
	wire next_int_fast_run;
	wire next_ext_fast_run;
	wire next_ext_slow_run;

	// on halt each clock survives only with its idle keep bit
	assign hs_keep_now = ~cpu_halt | hs_idle_keep;
	assign ls_keep_now = ~cpu_halt | ls_idle_keep;
	assign next_int_fast_run = int_fast_osc_en & hs_keep_now;
	assign next_ext_fast_run = ext_fast_osc_en & hs_keep_now;
	assign next_ext_slow_run = ext_slow_osc_en & ls_keep_now;

	// registered oscillator controls and operating mode status
	always @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			int_fast_osc_run <= 1'b0;
			ext_fast_osc_run <= 1'b0;
			ext_slow_osc_run <= 1'b0;
			ext_fast_drive_out <= 1'b0;
			ext_slow_speedup_out <= 1'b0;
			hs_clk_on <= 1'b0;
			ls_clk_on <= 1'b0;
			sleep_mode <= 1'b0;
		end
		else
		begin
			int_fast_osc_run <= next_int_fast_run;
			ext_fast_osc_run <= next_ext_fast_run;
			ext_slow_osc_run <= next_ext_slow_run;
			ext_fast_drive_out <= ext_fast_drive_mode;
			ext_slow_speedup_out <= ext_slow_speedup;
			hs_clk_on <= hs_keep_now;
			ls_clk_on <= ls_keep_now;
			sleep_mode <= cpu_halt & ~hs_idle_keep & ~ls_idle_keep;
		end
	end

	// ****************************************************************
	// stabilisation timers; flags low while stopped and after reset
	// ****************************************************************
	clkc_stab #(
		.CNT_W(STAB_CNT_W),
		.FAST_CYC(INT_FAST_STAB_CYC),
		.SLOW_CYC(INT_FAST_STAB_CYC)
	) u_int_fast_stab (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.osc_run(next_int_fast_run),
		.restart(ifc_restart),
		.fast_start(1'b1),
		.stable(int_fast_stable)
	);

	clkc_stab #(
		.CNT_W(STAB_CNT_W),
		.FAST_CYC(EXT_FAST_STAB_CYC),
		.SLOW_CYC(EXT_FAST_STAB_CYC)
	) u_ext_fast_stab (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.osc_run(next_ext_fast_run),
		.restart(efc_restart),
		.fast_start(1'b1),
		.stable(ext_fast_stable)
	);

	// speed-up trades power for a shorter settling time
	clkc_stab #(
		.CNT_W(STAB_CNT_W),
		.FAST_CYC(EXT_SLOW_FAST_CYC),
		.SLOW_CYC(EXT_SLOW_SLOW_CYC)
	) u_ext_slow_stab (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.osc_run(next_ext_slow_run),
		.restart(esc_restart),
		.fast_start(ext_slow_speedup),
		.stable(ext_slow_stable)
	);

	// internal frequency follows the field only while the oscillator is settled
	always @(posedge clk_sys)
	begin
		if (sys_rst)
			int_fast_freq_out <= `CLKC_FREQ_8M;
		else if (int_fast_stable)
			int_fast_freq_out <= int_fast_freq_sel;
	end

	// ****************************************************************
	// clock selection switch
	// ****************************************************************
	wire [4:0] sel_target;
	wire [4:0] sel_applied;
	wire sel_busy;

	assign sel_target = {sys_clk_div_sel, hs_source_sel, ls_source_sel};

	// bounded delay hides the glitch-free handover between clock trees
	clkc_switch #(
		.SEL_W(5)
	) u_switch (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.target(sel_target),
		.applied(sel_applied),
		.busy(sel_busy)
	);

	// applied selection drives the clock tree muxes
	always @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			sys_clk_div_out <= 3'h0;
			hs_source_out <= 1'b0;
			ls_source_out <= 1'b0;
			sys_on_slow <= 1'b0;
			clk_switching <= 1'b0;
		end
		else
		begin
			sys_clk_div_out <= sel_applied[4:2];
			hs_source_out <= sel_applied[1];
			ls_source_out <= sel_applied[0];
			sys_on_slow <= (sel_applied[4:2] == `CLKC_DIV_SLOW);
			clk_switching <= sel_busy | (sel_target != sel_applied);
		end
	end

endmodule

// ==== verilog/clkc_defs.vh ====
// constants shared by the clock control block: offsets, fields, resets, timing
`ifndef CLKC_DEFS_VH
`define CLKC_DEFS_VH

// ****************************************************************
// register byte offsets on the apb bus
// ****************************************************************
`define CLKC_OFF_SYS_CLK_CTRL 4'h0
`define CLKC_OFF_INT_FAST_CTRL 4'h4
`define CLKC_OFF_EXT_FAST_CTRL 4'h8
`define CLKC_OFF_EXT_SLOW_CTRL 4'hc

// ****************************************************************
// reset values of the four 8-bit registers
// ****************************************************************
`define CLKC_RST_SYS_CLK_CTRL 8'h00
`define CLKC_RST_INT_FAST_CTRL 8'h01
`define CLKC_RST_EXT_FAST_CTRL 8'h00
`define CLKC_RST_EXT_SLOW_CTRL 8'h00

// ****************************************************************
// field positions
// ****************************************************************
`define CLKC_DIV_HI 7
`define CLKC_DIV_LO 5
`define CLKC_HS_SRC 3
`define CLKC_LS_SRC 2
`define CLKC_HS_KEEP 1
`define CLKC_LS_KEEP 0
`define CLKC_FREQ_HI 3
`define CLKC_FREQ_LO 2
`define CLKC_MODE_BIT 2
`define CLKC_STABLE_BIT 1
`define CLKC_EN_BIT 0

// ****************************************************************
// encodings
// ****************************************************************
`define CLKC_DIV_SLOW 3'h7
`define CLKC_FREQ_8M 2'h0
`define CLKC_FREQ_12M 2'h1
`define CLKC_FREQ_16M 2'h2

// ****************************************************************
// timing: switch delay in current clock periods, plus resync allowance
// ****************************************************************
`define CLKC_SW_BASE_PER 4
`define CLKC_SW_EXTRA_PER 1
`define CLKC_SW_CYC (`CLKC_SW_BASE_PER + `CLKC_SW_EXTRA_PER)

`endif

// ==== verilog/clkc_stab.v ====
// oscillator stabilisation timer producing one stable flag
`timescale 1ns/100ps
module clkc_stab #(
	parameter CNT_W = 16,
	parameter FAST_CYC = 1024,
	parameter SLOW_CYC = 4096
)(
	input wire clk_sys,
	input wire sys_rst,
	input wire osc_run,
	input wire restart,
	input wire fast_start,
	output reg stable
);
	reg [CNT_W-1:0] cnt;
	wire [CNT_W-1:0] limit;

	// fast start picks the shorter settling time
	assign limit = fast_start ? FAST_CYC[CNT_W-1:0] : SLOW_CYC[CNT_W-1:0];

	// flag drops on stop or restart, then rises once the count elapses
	always @(posedge clk_sys)
	begin
		if (sys_rst || !osc_run || restart)
		begin
			cnt <= {CNT_W{1'b0}};
			stable <= 1'b0;
		end
		else if (!stable)
		begin
			if (cnt == limit - 1'b1)
				stable <= 1'b1;
			else
				cnt <= cnt + 1'b1;
		end
	end
endmodule

// ==== verilog/clkc_switch.v ====
// clock selection switcher: applies a new selection after the switch delay
`timescale 1ns/100ps
`include "clkc_defs.vh"
module clkc_switch #(
	parameter SEL_W = 5
)(
	input wire clk_sys,
	input wire sys_rst,
	input wire [SEL_W-1:0] target,
	output reg [SEL_W-1:0] applied,
	output reg busy
);
	reg [SEL_W-1:0] pend;
	reg [3:0] cnt;

	// a change made during a switch restarts the wait for the newest target
	always @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			applied <= {SEL_W{1'b0}};
			pend <= {SEL_W{1'b0}};
			busy <= 1'b0;
			cnt <= 4'h0;
		end
		else if (busy && target != pend)
		begin
			pend <= target;
			cnt <= 4'h0;
		end
		else if (busy)
		begin
			if (cnt == `CLKC_SW_CYC - 2)
			begin
				applied <= pend;
				busy <= 1'b0;
			end
			else
				cnt <= cnt + 4'h1;
		end
		else if (target != applied)
		begin
			pend <= target;
			busy <= 1'b1;
			cnt <= 4'h0;
		end
	end
endmodule

// ==== tb/clkc_ctrl_checker.sv ====
// concurrent checks on the ports of the clock control block
`timescale 1ns/100ps
module clkc_ctrl_checker (
	input logic clk_sys,
	input logic sys_rst,
	input logic psel,
	input logic penable,
	input logic pready,
	input logic pslverr,
	input logic [31:0] prdata,
	input logic cpu_halt,
	input logic xtal_pins_en,
	input logic int_fast_osc_run,
	input logic [1:0] int_fast_freq_out,
	input logic ext_fast_osc_run,
	input logic ext_fast_drive_out,
	input logic ext_slow_osc_run,
	input logic ext_slow_speedup_out,
	input logic [2:0] sys_clk_div_out,
	input logic ls_source_out,
	input logic sys_on_slow,
	input logic hs_clk_on,
	input logic ls_clk_on,
	input logic sleep_mode,
	input logic clk_switching
);
	// ****************
	// one clock domain, reset disables all
	// ****************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	AST_PREADY_PULSE: assert property (pready |=> !pready)
		else $error("pready held too long");
	AST_ERR_WITH_READY: assert property (pslverr |-> pready && $past(psel && penable))
		else $error("pslverr outside an answer");
	AST_RD_UPPER_ZERO: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	AST_SLOW_CODE: assert property (sys_on_slow == (sys_clk_div_out == 3'h7))
		else $error("slow flag disagrees with divider");
	AST_APPLY_AFTER_SWITCH: assert property ($changed(sys_clk_div_out) |->
		$past(clk_switching))
		else $error("divider changed without a switch");
	AST_SWITCH_BOUND: assert property ($rose(clk_switching) |-> ##[1:7] !clk_switching)
		else $error("switch took too long");
	AST_CLK_KEEP: assert property (!cpu_halt && !$past(sys_rst) |=> hs_clk_on && ls_clk_on)
		else $error("clock off while running");
	AST_SLEEP_CLKS: assert property (sleep_mode |-> !hs_clk_on && !ls_clk_on)
		else $error("clock on in sleep");
	AST_DRIVE_LOCK: assert property ($changed(ext_fast_drive_out) |->
		!$past(xtal_pins_en && ext_fast_osc_run))
		else $error("drive mode changed while locked");
	AST_SPEEDUP_LOCK: assert property ($changed(ext_slow_speedup_out) |->
		!$past(sys_on_slow && ls_source_out))
		else $error("speed-up changed while locked");
	AST_FREQ_RUN: assert property ($changed(int_fast_freq_out) |->
		$past(int_fast_osc_run))
		else $error("frequency applied while stopped");
	AST_EXT_RESET: assert property ($fell(sys_rst) |->
		(!ext_fast_osc_run && !ext_slow_osc_run)[*2])
		else $error("external oscillator on after reset");
	AST_INT_RESET: assert property ($fell(sys_rst) && !cpu_halt |->
		##[1:2] int_fast_osc_run)
		else $error("internal oscillator off after reset");
endmodule
bind clkc_ctrl clkc_ctrl_checker chk (
	.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .prdata(prdata), .cpu_halt(cpu_halt), .xtal_pins_en(xtal_pins_en),
	.int_fast_osc_run(int_fast_osc_run), .int_fast_freq_out(int_fast_freq_out),
	.ext_fast_osc_run(ext_fast_osc_run), .ext_fast_drive_out(ext_fast_drive_out),
	.ext_slow_osc_run(ext_slow_osc_run), .ext_slow_speedup_out(ext_slow_speedup_out),
	.sys_clk_div_out(sys_clk_div_out), .ls_source_out(ls_source_out),
	.sys_on_slow(sys_on_slow), .hs_clk_on(hs_clk_on), .ls_clk_on(ls_clk_on),
	.sleep_mode(sleep_mode), .clk_switching(clk_switching));

// ==== tb/clkc_ctrl_bench.sv ====
// self-checking bench for the clock control block
`timescale 1ns/100ps
module clkc_ctrl_bench;
	// ****************
	// signals, register shadows, stabilisation table
	// ****************
	localparam int SN[4] = '{16, 18, 20, 30};
	localparam logic [3:0] SA[4] = '{4'h4, 4'h8, 4'hc, 4'hc};
	localparam logic [7:0] SD[4] = '{8'h09, 8'h01, 8'h05, 8'h01};
	logic clk_sys = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic cpu_halt = 0, xtal_pins_en = 0, pready, pslverr, rerr;
	logic [3:0] paddr = 4'h0;
	logic [31:0] pwdata = 32'h0, prdata, rdat, rv;
	logic int_fast_osc_run, ext_fast_osc_run, ext_fast_drive_out, ext_slow_osc_run;
	logic ext_slow_speedup_out, hs_source_out, ls_source_out, sys_on_slow;
	logic hs_clk_on, ls_clk_on, sleep_mode, clk_switching;
	logic [1:0] int_fast_freq_out;
	logic [2:0] sys_clk_div_out;
	logic [7:0] sc = 8'h00, ic = 8'h01, xc = 8'h00, lc = 8'h00;
	integer seed = 33, err_total = 0, checks = 0, k, n;
	// short counts keep the run brief
	clkc_ctrl #(.INT_FAST_STAB_CYC(SN[0]), .EXT_FAST_STAB_CYC(SN[1]),
		.EXT_SLOW_FAST_CYC(SN[2]), .EXT_SLOW_SLOW_CYC(SN[3])) uut (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cpu_halt(cpu_halt), .xtal_pins_en(xtal_pins_en), .int_fast_osc_run(int_fast_osc_run),
		.int_fast_freq_out(int_fast_freq_out), .ext_fast_osc_run(ext_fast_osc_run),
		.ext_fast_drive_out(ext_fast_drive_out), .ext_slow_osc_run(ext_slow_osc_run),
		.ext_slow_speedup_out(ext_slow_speedup_out), .sys_clk_div_out(sys_clk_div_out),
		.hs_source_out(hs_source_out), .ls_source_out(ls_source_out),
		.sys_on_slow(sys_on_slow), .hs_clk_on(hs_clk_on), .ls_clk_on(ls_clk_on),
		.sleep_mode(sleep_mode), .clk_switching(clk_switching));
	always #4 clk_sys = ~clk_sys;
	// ****************
	// expectation, compare and bus tasks
	// ****************
	function automatic logic [31:0] exp_rd(input logic [3:0] a);
		return a == 4'h0 ? sc : a == 4'h4 ? ic : a == 4'h8 ? xc : a == 4'hc ? lc : 8'h00;
	endfunction
	function automatic logic [31:0] exp_out(input logic h);
		return {sc[7:5] == 3'h7, !h | sc[1], !h | sc[0], h & !sc[1] & !sc[0],
			ic[0] & (!h | sc[1]), xc[0] & (!h | sc[1]), lc[0] & (!h | sc[0]), xc[2], lc[2]};
	endfunction
	task chk(input logic [31:0] e, input logic [31:0] g, input string s);
		checks++;
		if (g !== e)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// request held until pready is seen at an edge
	task apb(input logic w, input logic [3:0] a, input logic [7:0] d);
		integer t;
		@(posedge clk_sys);
		rv = $random(seed);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {rv[23:0], d};
		@(posedge clk_sys);
		penable <= 1'b1;
		for (t = 0; t < 20 && pready !== 1'b1; t++)
			@(posedge clk_sys);
		if (pready !== 1'b1)
		begin
			err_total++;
			tally_and_finish;
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// update shadows, write, wait for the switch, read back
	task wr(input logic [3:0] a, input logic [7:0] d);
		if (a == 4'h4 && d[3:2] == 2'b11)
			d[3] = 1'b0;
		if (a == 4'h8 && xtal_pins_en && xc[0] != d[0])
			d[2] = xc[2];
		case (a)
			4'h0: sc = d & 8'hef;
			4'h4: ic = d & 8'h0d;
			4'h8: xc = {5'h0, xtal_pins_en && xc[0] ? xc[2] : d[2], 1'b0, d[0]};
			4'hc: lc = {5'h0, sc[7:5] == 3'h7 && sc[2] ? lc[2] : d[2], 1'b0, d[0]};
			default: ;
		endcase
		apb(1'b1, a, d);
		chk(a[1:0] != 2'b00, rerr, "write error");
		// software holds off until the new selection is in force
		for (n = 0; n < 12 && {sys_clk_div_out, hs_source_out, ls_source_out} !==
			{sc[7:5], sc[3:2]}; n++)
		begin
			@(posedge clk_sys);
			#1;
		end
		if (n == 12)
		begin
			err_total++;
			tally_and_finish;
		end
		chk(1, n <= 6, "switch cycles");
		apb(1'b0, a, 8'h00);
		chk(a[1:0] != 2'b00, rerr, "read error");
		chk(exp_rd(a), a == 4'h0 ? rdat : rdat & ~32'h2, "readback");
		chk(exp_out(cpu_halt), {sys_on_slow, hs_clk_on, ls_clk_on, sleep_mode, int_fast_osc_run,
			ext_fast_osc_run, ext_slow_osc_run, ext_fast_drive_out, ext_slow_speedup_out},
			"outputs");
	endtask
	// ****************
	// main sequence
	// ****************
	initial
	begin
		repeat (20) @(posedge clk_sys);
		sys_rst <= 1'b0;
		for (k = 0; k < 4; k++)
		begin
			apb(1'b0, {k[1:0], 2'b00}, 8'h00);
			chk(exp_rd({k[1:0], 2'b00}), rdat & ~32'h2, "reset value");
		end
		chk(exp_out(1'b0), {sys_on_slow, hs_clk_on, ls_clk_on, sleep_mode, int_fast_osc_run,
			ext_fast_osc_run, ext_slow_osc_run, ext_fast_drive_out, ext_slow_speedup_out},
			"reset out");
		$display("reset test done");
		wr(4'h0, 8'h03);
		wr(4'h4, 8'h05);
		repeat (40) @(posedge clk_sys);
		for (k = 0; k < 4; k++)
		begin
			wr(SA[k], SD[k] & 8'hfe);
			apb(1'b0, SA[k], 8'h00);
			chk(0, rdat[1], "stable while off");
			wr(SA[k], SD[k]);
			apb(1'b0, SA[k], 8'h00);
			chk(0, rdat[1], "stable restart");
			if (k == 0)
				chk(1, int_fast_freq_out, "freq held");
			repeat (SN[k] - 16) @(posedge clk_sys);
			apb(1'b0, SA[k], 8'h00);
			chk(0, rdat[1], "stable early");
			repeat (12) @(posedge clk_sys);
			apb(1'b0, SA[k], 8'h00);
			chk(1, rdat[1], "stable set");
		end
		chk(2, int_fast_freq_out, "freq applied");
		$display("stable test done");
		for (k = 0; k < 8; k++)
			wr(4'h0, {k[2:0], 1'b0, k[0], k == 7, 2'b11});
		wr(4'hc, {5'h0, ~lc[2], 2'b01});
		wr(4'h0, 8'h00);
		wr(4'hc, {5'h0, ~lc[2], 2'b01});
		wr(4'h6, 8'hff);
		$display("select test done");
		// pin state settles one edge before the shadows read it
		@(posedge clk_sys);
		xtal_pins_en <= 1'b1;
		@(posedge clk_sys);
		wr(4'h8, 8'h01);
		wr(4'h8, {5'h0, ~xc[2], 2'b01});
		$display("drive lock test done");
		// random traffic, halts and pin states mixed in
		repeat (60)
		begin
			@(posedge clk_sys);
			cpu_halt <= $random(seed);
			xtal_pins_en <= $random(seed);
			@(posedge clk_sys);
			k = {$random(seed)} % 5;
			rv = $random(seed);
			wr(k == 4 ? 4'h6 : {k[1:0], 2'b00}, rv[7:0]);
		end
		$display("random test done");
		tally_and_finish;
	end
endmodule
